// ===== hdl/sol_pkg.sv
package sol_pkg;
  localparam logic [7:0]  CFG_ADDR      = 8'h00;
  localparam logic [7:0]  STAT_ADDR     = 8'h04;
  localparam logic [7:0]  CTRL_ADDR     = 8'h08;
  localparam int          CFG_EEPROM    = 9;
  localparam int          CFG_WIDTH_LO  = 6;
  localparam int          CFG_WIDTH_HI  = 7;
  localparam int          CFG_ORDER     = 10;
  localparam int          CFG_RSVD      = 0;
  localparam int          CTRL_SWPD     = 0;
  localparam int          CTRL_MODE_LO  = 1;
  localparam int          CTRL_MODE_HI  = 2;
  localparam int          SETTLE_CYCLES = 4;
  localparam logic [31:0] CFG_RESET     = 32'h0000_0000;
  localparam logic [31:0] CTRL_RESET    = 32'h0000_0000;
  localparam logic [3:0]  STRAP_DEFAULT = 4'hE;
  typedef enum logic [1:0]
  {
    SOL_CAPTURE = 2'b00,
    SOL_RUN     = 2'b01,
    SOL_DOWN    = 2'b10
  } sol_state_t;
endpackage : sol_pkg

// ===== hdl/sol_led_mux.sv
`timescale 1ns/1ps
module sol_led_mux
  import sol_pkg::*;
(
  input  wire logic       link,
  input  wire logic       act,
  input  wire logic       speed_100,
  input  wire logic       full_duplex,
  input  wire logic [1:0] mode,
  output logic            led_a_n,
  output logic            led_b_n
);
  logic on_a;
  logic on_b;
  always_comb
  begin
    case (mode)
      2'b00:
      begin
        on_b = speed_100;
        on_a = link | act;
      end
      2'b01:
      begin
        on_b = act;
        on_a = link;
      end
      2'b10:
      begin
        on_b = full_duplex;
        on_a = link | act;
      end
      default:
      begin
        on_b = full_duplex;
        on_a = link;
      end
    endcase
    led_a_n = ~on_a;
    led_b_n = ~on_b;
  end
endmodule : sol_led_mux

// ===== hdl/sol_strap_latch.sv
// Local design decisions: the APB register port and the register offsets.
`timescale 1ns/1ps
module sol_strap_latch
  import sol_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic        hw_reset_n,
  input  wire logic        hw_power_down,
  input  wire logic        eeprom_strap_in,
  input  wire logic        port1_led_b_in,
  input  wire logic        bus_width_strap_in,
  input  wire logic        byte_order_strap_in,
  output logic             eeprom_strap_out,
  output logic             port1_led_b_out,
  output logic             bus_width_strap_out,
  output logic             byte_order_strap_out,
  output logic             port2_led_b_out,
  output logic             strap_oe,
  output logic             eeprom_present,
  output logic             bus_16bit,
  output logic             little_endian,
  input  wire logic [1:0]  port_link,
  input  wire logic [1:0]  port_act,
  input  wire logic [1:0]  port_speed_100,
  input  wire logic [1:0]  port_full_duplex,
  input  wire logic        wake_event,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr
);
  import sol_pkg::*;
  typedef struct packed {
    logic [1:0]  rn_sync;
    logic [1:0]  pd_sync;
    logic [7:0]  pin_sync;
    sol_state_t  state;
    logic [2:0]  settle;
    logic [3:0]  strap;
    logic [31:0] ctrl;
    logic [31:0] rdata;
    logic        err;
  } sol_reg_t;
  sol_reg_t r_ff;
  sol_reg_t nxt_r;
  logic [3:0] pins;
  logic       held;
  logic       led1a;
  logic       led1b;
  logic       led2a;
  logic       led2b;
  logic [31:0] cfg;
  assign pins = {byte_order_strap_in, bus_width_strap_in, port1_led_b_in, eeprom_strap_in};
  assign held = ~r_ff.rn_sync[1] | r_ff.pd_sync[1] | r_ff.ctrl[CTRL_SWPD];
  always_comb
  begin
    cfg = CFG_RESET;
    cfg[CFG_EEPROM] = r_ff.strap[0];
    cfg[CFG_WIDTH_HI] = r_ff.strap[2];
    cfg[CFG_WIDTH_LO] = r_ff.strap[2];
    cfg[CFG_ORDER] = r_ff.strap[3];
    cfg[CFG_RSVD] = ~r_ff.strap[1];
  end
  always_comb
  begin
    nxt_r = r_ff;
    nxt_r.rn_sync = {r_ff.rn_sync[0], hw_reset_n};
    nxt_r.pd_sync = {r_ff.pd_sync[0], hw_power_down};
    nxt_r.pin_sync = {r_ff.pin_sync[3:0], pins};
    nxt_r.err = 1'b0;
    case (r_ff.state)
      SOL_CAPTURE:
      begin
        if (held)
          nxt_r.settle = 3'd0;
        else if (r_ff.settle == 3'(SETTLE_CYCLES))
        begin
          nxt_r.strap = r_ff.pin_sync[7:4];
          nxt_r.state = SOL_RUN;
        end
        else
          nxt_r.settle = r_ff.settle + 3'd1;
      end
      SOL_RUN:
      begin
        if (held)
        begin
          nxt_r.state = SOL_DOWN;
          nxt_r.settle = 3'd0;
        end
      end
      default:
      begin
        nxt_r.state = SOL_CAPTURE;
      end
    endcase
    // read data and error loaded in setup, valid through access
    if (psel && !penable)
    begin
      if (paddr == CFG_ADDR)
        nxt_r.rdata = cfg;
      else if (paddr == STAT_ADDR)
        nxt_r.rdata = {30'h0000_0000, r_ff.state};
      else if (paddr == CTRL_ADDR)
        nxt_r.rdata = r_ff.ctrl;
      else
      begin
        nxt_r.rdata = 32'h0000_0000;
        nxt_r.err = 1'b1;
      end
    end
    if (psel && penable && pwrite && paddr == CTRL_ADDR)
      nxt_r.ctrl = {29'h0000_0000, pwdata[2:0]};
  end
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      r_ff.rn_sync <= 2'b00;
      r_ff.pd_sync <= 2'b00;
      r_ff.pin_sync <= 8'h00;
      r_ff.state <= SOL_CAPTURE;
      r_ff.settle <= 3'd0;
      r_ff.strap <= STRAP_DEFAULT;
      r_ff.ctrl <= CTRL_RESET;
      r_ff.rdata <= 32'h0000_0000;
      r_ff.err <= 1'b0;
    end
    else
      r_ff <= nxt_r;
  end
  assign strap_oe = (r_ff.state == SOL_RUN);
  assign eeprom_present = r_ff.strap[0];
  assign bus_16bit = r_ff.strap[2];
  assign little_endian = r_ff.strap[3];
  assign prdata = r_ff.rdata;
  assign pready = 1'b1;
  assign pslverr = r_ff.err;
  assign eeprom_strap_out = wake_event;
  assign port1_led_b_out = led1b;
  assign bus_width_strap_out = led1a;
  assign byte_order_strap_out = led2a;
  assign port2_led_b_out = led2b;
  sol_led_mux u_led1
  (
    .link        (port_link[0]),
    .act         (port_act[0]),
    .speed_100   (port_speed_100[0]),
    .full_duplex (port_full_duplex[0]),
    .mode        (r_ff.ctrl[CTRL_MODE_HI:CTRL_MODE_LO]),
    .led_a_n     (led1a),
    .led_b_n     (led1b)
  );
  sol_led_mux u_led2
  (
    .link        (port_link[1]),
    .act         (port_act[1]),
    .speed_100   (port_speed_100[1]),
    .full_duplex (port_full_duplex[1]),
    .mode        (r_ff.ctrl[CTRL_MODE_HI:CTRL_MODE_LO]),
    .led_a_n     (led2a),
    .led_b_n     (led2b)
  );
  sequence capture_done_s;
    r_ff.state == SOL_CAPTURE && !held && r_ff.settle == 3'(SETTLE_CYCLES);
  endsequence
  strap_held_a: assert property (@(posedge clk) disable iff (rst)
    r_ff.state == SOL_RUN && $past(r_ff.state) == SOL_RUN |-> $stable(r_ff.strap))
    else $error("strap changed while running");
  capture_a: assert property (@(posedge clk) disable iff (rst)
    capture_done_s |=> r_ff.strap == $past(r_ff.pin_sync[7:4]) && r_ff.state == SOL_RUN)
    else $error("strap not captured");
  eeprom_bit_a: assert property (@(posedge clk) disable iff (rst)
    psel && !penable && paddr == CFG_ADDR && r_ff.state == SOL_RUN |=> prdata[CFG_EEPROM] == eeprom_present)
    else $error("eeprom bit wrong");
  width_bit_a: assert property (@(posedge clk) disable iff (rst)
    psel && !penable && paddr == CFG_ADDR && r_ff.state == SOL_RUN
    |=> prdata[CFG_WIDTH_HI] == bus_16bit && prdata[CFG_WIDTH_LO] == bus_16bit)
    else $error("width bits wrong");
  order_bit_a: assert property (@(posedge clk) disable iff (rst)
    psel && !penable && paddr == CFG_ADDR && r_ff.state == SOL_RUN |=> prdata[CFG_ORDER] == little_endian)
    else $error("order bit wrong");
  recapture_a: assert property (@(posedge clk) disable iff (rst)
    r_ff.state == SOL_RUN && held |=> r_ff.state == SOL_DOWN ##1 r_ff.state == SOL_CAPTURE)
    else $error("no recapture");
  pins_input_a: assert property (@(posedge clk) disable iff (rst)
    r_ff.state == SOL_RUN && held |=> !strap_oe)
    else $error("pins driven during capture");
  speed_led_a: assert property (@(posedge clk) disable iff (rst)
    r_ff.ctrl[CTRL_MODE_HI:CTRL_MODE_LO] == 2'b00 |-> led1b == ~port_speed_100[0])
    else $error("speed led wrong");
  duplex_led_a: assert property (@(posedge clk) disable iff (rst)
    r_ff.ctrl[CTRL_MODE_HI] |-> led2b == ~port_full_duplex[1])
    else $error("duplex led wrong");
endmodule : sol_strap_latch

// ===== tb/sol_board.sv
`timescale 1ns/1ps
module sol_board (
  input  wire logic       clk,
  input  wire logic       strap_oe,
  input  wire logic [3:0] pin_out,
  input  wire logic [3:0] pull,
  input  wire logic       rst_req,
  output logic [3:0]      pin_in,
  output logic            hw_reset_n
);
  int hold_ff;
  // pulls seen only while pins are inputs, reserved strap kept high
  assign pin_in = strap_oe ? pin_out : (pull | 4'b0010);
  // reset low for a scaled minimum hold
  always_ff @(posedge clk)
    hold_ff <= rst_req ? 10 : (hold_ff > 0 ? hold_ff - 1 : 0);
  assign hw_reset_n = (hold_ff == 0);
endmodule : sol_board

// ===== tb/strap_option_latch_test.sv
`timescale 1ns/1ps
module strap_option_latch_test;
  import sol_pkg::*;
  logic clk = 0, rst = 1, pd = 0, rst_req = 0, psel = 0, penable = 0, pwrite = 0, wake = 0;
  logic pready, pslverr, strap_oe, ee, w16, le, hrn, p2b, err;
  logic [3:0] pull = 4'hF, pin_in, pin_out;
  logic [1:0] link = 2'h3, spd = 2'h1, dup = 2'h2;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0000_0000, prdata, r;
  logic [7:0] rows [4] = '{8'hFE, 8'h20, 8'hBA, 8'h76};
  int num_errors = 0, comparisons = 0;
  always #4 clk = ~clk;
  sol_board board (.clk(clk), .strap_oe(strap_oe), .pin_out(pin_out), .pull(pull), .rst_req(rst_req),
    .pin_in(pin_in), .hw_reset_n(hrn));
  sol_strap_latch dut (.clk(clk), .rst(rst), .hw_reset_n(hrn), .hw_power_down(pd),
    .eeprom_strap_in(pin_in[0]), .port1_led_b_in(pin_in[1]), .bus_width_strap_in(pin_in[2]),
    .byte_order_strap_in(pin_in[3]), .eeprom_strap_out(pin_out[0]), .port1_led_b_out(pin_out[1]),
    .bus_width_strap_out(pin_out[2]), .byte_order_strap_out(pin_out[3]), .port2_led_b_out(p2b),
    .strap_oe(strap_oe), .eeprom_present(ee), .bus_16bit(w16), .little_endian(le), .port_link(link),
    .port_act(2'b00), .port_speed_100(spd), .port_full_duplex(dup), .wake_event(wake), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr));
  task chk(input string n, input logic [31:0] e, input logic [31:0] g);
    comparisons++;
    if (g !== e)
    begin
      num_errors++;
      $display("[FAIL] %s expected %h seen %h", n, e, g);
    end
  endtask : chk
  task apb(input logic [7:0] a, input logic w, input logic [31:0] d, output logic [31:0] q, output logic e);
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1) @(posedge clk);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task cap(input int k);
    int n;
    if (k == 0) rst_req <= 1;
    if (k == 1) pd <= 1;
    if (k == 2) apb(CTRL_ADDR, 1, 32'h0000_0001, r, err);
    repeat (6) @(posedge clk);
    rst_req <= 0;
    pd <= 0;
    chk("oe_low", 1'b0, strap_oe);
    if (k == 2) apb(CTRL_ADDR, 1, 32'h0000_0000, r, err);
    for (n = 0; n < 100 && strap_oe !== 1; n++) @(posedge clk);
    chk("oe_high", 1'b1, strap_oe);
  endtask : cap
  task tally_and_finish;
    $display("errors %0d comparisons %0d", num_errors, comparisons);
    if (num_errors == 0 && comparisons > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : tally_and_finish
  initial
  begin
    #200000;
    num_errors++;
    tally_and_finish();
  end
  initial
  begin
    repeat (4) @(posedge clk);
    chk("oe_rst", 1'b0, strap_oe);
    rst <= 0;
    @(posedge clk);
    foreach (rows[i])
    begin
      pull <= rows[i][7:4];
      cap(i % 3);
      chk("caps", rows[i][3:1], {le, w16, ee});
      apb(CFG_ADDR, 0, 32'h0000_0000, r, err);
      chk("cfg", {rows[i][3:2], rows[i][2:0]}, {r[10], r[7], r[6], r[9], r[0]});
    end
    pull <= ~pull;
    repeat (10) @(posedge clk);
    chk("hold", rows[3][3:1], {le, w16, ee});
    for (int m = 0; m < 4; m++)
    begin
      apb(CTRL_ADDR, 1, m << 1, r, err);
      link <= 2'h3;
      wake <= m[0];
      @(posedge clk);
      chk("led_on", {m < 2, 2'b00, m != 0}, {p2b, pin_out[3:1]});
      chk("wake", m[0], pin_out[0]);
      link <= 2'h0;
      @(posedge clk);
      chk("led_off", {m < 2, 2'b11, m != 0}, {p2b, pin_out[3:1]});
    end
    apb(8'hFC, 0, 32'h0000_0000, r, err);
    chk("slverr", 1'b1, err);
    rst <= 1'b1;
    @(posedge clk);
    chk("rst_oe", 1'b0, strap_oe);
    chk("rst_def", 3'b110, {le, w16, ee});
    rst <= 1'b0;
    for (int n = 0; n < 100 && strap_oe !== 1'b1; n++) @(posedge clk);
    chk("rst_oe_high", 1'b1, strap_oe);
    chk("rst_caps", 3'b100, {le, w16, ee});
    tally_and_finish();
  end
endmodule : strap_option_latch_test
